// ===== src/pcn_pkg.sv
/*
 * Constants for the setpoint pulse counter: image byte indices, status
 * byte layout, counter limits and the counter state encoding.
 * Assumes the host exchanges a four-byte image one byte per strobe.
 */
package pcn_pkg;

	// Output image (host to device) byte indices
	localparam logic [1:0] OUT_IDX_SP1_HI = 2'h0;
	localparam logic [1:0] OUT_IDX_SP1_LO = 2'h1;
	localparam logic [1:0] OUT_IDX_SP2_HI = 2'h2;
	localparam logic [1:0] OUT_IDX_SP2_LO = 2'h3;

	// Input image (device to host) byte indices
	localparam logic [1:0] IN_IDX_UNUSED = 2'h0;
	localparam logic [1:0] IN_IDX_STATUS = 2'h1;
	localparam logic [1:0] IN_IDX_CNT_HI = 2'h2;
	localparam logic [1:0] IN_IDX_CNT_LO = 2'h3;

	// Register offsets of the image map
	localparam logic [1:0] FIRST_SETPOINT_OFS = 2'h0;
	localparam logic [1:0] STATUS_FLAGS_OFS = 2'h1;
	localparam logic [1:0] SECOND_SETPOINT_OFS = 2'h2;
	localparam logic [1:0] CURRENT_COUNT_OFS = 2'h2;

	// Status byte fields
	localparam int ST_SYNC_BIT = 0;
	localparam int ST_HIT1_BIT = 1;
	localparam int ST_HIT2_BIT = 2;
	localparam int ST_OVF_BIT = 3;
	localparam int ST_MODE_BIT = 4;
	localparam int ST_RES_LSB = 5;
	localparam int ST_RES_MSB = 6;

	localparam int NUM_SP = 2;
	localparam int NUM_IN = 2;
	localparam int IN_CNT = 0;
	localparam int IN_GATE = 1;

	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		CST_STOPPED = 2'b01,
		CST_COUNTING = 2'b10
	} pcn_cnt_state_t;

endpackage : pcn_pkg

// ===== src/pcn_sync_edge.sv
/*
 * Two-stage synchroniser plus edge detector for a group of input pins.
 * Assumes the pins are slow against ref_clk; each edge pulses once.
 */
`timescale 1ns/1ns
module pcn_sync_edge
	import pcn_pkg::*;
#(
	parameter int WIDTH = NUM_IN
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Raw pins
	input wire logic [WIDTH-1:0] pin_in,
	// Synchronised level and edges
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_bit
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
					prev_reg[gi] <= 1'b0;
				end
				else
				begin
					meta_reg[gi] <= pin_in[gi];
					sync_reg[gi] <= meta_reg[gi];
					prev_reg[gi] <= sync_reg[gi];
				end
			end
			// Edge by sample compare, only past the second stage
			assign level[gi] = sync_reg[gi];
			assign rise[gi] = sync_reg[gi] & ~prev_reg[gi];
			assign fall[gi] = ~sync_reg[gi] & prev_reg[gi];
		end
	endgenerate

endmodule : pcn_sync_edge

// ===== src/pcn_counter.sv
/*
 * Counter-mode core of the setpoint pulse counter: four-byte image
 * exchange, gated up-counter, two setpoints with reached flags and outputs.
 * Assumes the host image strobes and controller state inputs are synchronous
 * to ref_clk; count and gate pins may be asynchronous.
 */
// Summary of operation
// - Host writes setpoint one in bytes 0,1 and two in 2,3, high first.
// - Input image byte 0 reads zero, byte 1 is the status byte.
// - Input bytes 2 and 3 hold count high and low byte.
// - Status shows resolution, mode, both reached flags and sync flag.
// - Up-counter on count rising edges, only while gate high.
// - New setpoint takes effect at once while its reached flag is clear.
// - With reached flag set, new setpoint waits for next gate rise.
// - Unwritten setpoints read as zero.
// - Gate rise clears count, flags, outputs and enables counting.
// - Gate fall stops counting, leaves count, outputs and flags.
// - Each enabled count edge adds exactly one.
// - Count reaching a setpoint sets its output and reached flag.
// - Count is presented unsigned over the full 16 bits.
// - A zero setpoint switches its output on at gate rise.
// - Controller leaving run switches both outputs off.
// - Enabled count passing 65535 sets overflow, status bit 3.
// - Overflow freezes flags and blocks output switch-on until cleared; stop or cold restart still switch outputs off.
// - Counting continues after overflow.
// - Gate rise or overall reset clears overflow and the counter.
// - After cold restart outputs stay off until next gate rise.
// - Sync flag sits in status bit 0.
`timescale 1ns/1ns
module pcn_counter
	import pcn_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Field pins
	input wire logic count_pin,
	input wire logic gate_pin,
	output logic out_q0,
	output logic out_q1,
	// Mode switch and sync source
	input wire logic mode_sel,
	input wire logic [1:0] resolution_sel,
	input wire logic ref_sync,
	// Controller state
	input wire logic ctl_run,
	input wire logic ctl_overall_reset,
	input wire logic ctl_cold_restart,
	// Output image write port
	input wire logic img_wr,
	input wire logic [1:0] img_wr_idx,
	input wire logic [7:0] img_wr_data,
	// Input image read port
	input wire logic img_rd,
	input wire logic [1:0] img_rd_idx,
	output logic [7:0] img_rd_data,
	output logic img_rd_valid
);

	logic [NUM_IN-1:0] pin_rise;
	logic [NUM_IN-1:0] pin_fall;

	pcn_sync_edge #(.WIDTH(NUM_IN)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.pin_in({gate_pin, count_pin}),
		.level(),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	logic cnt_edge;
	logic gate_rise;
	logic gate_fall;
	assign cnt_edge = pin_rise[IN_CNT];
	assign gate_rise = pin_rise[IN_GATE];
	assign gate_fall = pin_fall[IN_GATE];

	// Counter state
	pcn_cnt_state_t state_reg;
	pcn_cnt_state_t state_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic ovf_reg;
	logic ovf_next;
	logic run_prev_reg;
	logic run_prev_next;
	logic block_reg;
	logic block_next;
	logic sync_reg;
	logic sync_next;
	logic run_fall;

	assign run_fall = run_prev_reg & ~ctl_run;

	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		ovf_next = ovf_reg;
		block_next = block_reg;
		run_prev_next = ctl_run;
		sync_next = ref_sync;
		unique case (state_reg)
			CST_STOPPED:
			begin
				if (gate_rise)
					state_next = CST_COUNTING;
			end
			CST_COUNTING:
			begin
				if (gate_fall)
					state_next = CST_STOPPED;
				else if (cnt_edge)
				begin
					// Unsigned 16-bit wrap keeps counting past overflow
					count_next = count_reg + CNT_ONE;
					if (count_reg == CNT_MAX)
						ovf_next = 1'b1;
				end
			end
		endcase
		if (ctl_overall_reset)
		begin
			count_next = CNT_ZERO;
			ovf_next = 1'b0;
		end
		if (ctl_cold_restart)
			block_next = 1'b1;
		if (gate_rise)
		begin
			count_next = CNT_ZERO;
			ovf_next = 1'b0;
			block_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= CST_STOPPED;
			count_reg <= CNT_ZERO;
			ovf_reg <= 1'b0;
			block_reg <= 1'b0;
			run_prev_reg <= 1'b0;
			sync_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
			ovf_reg <= ovf_next;
			block_reg <= block_next;
			run_prev_reg <= run_prev_next;
			sync_reg <= sync_next;
		end
	end

	// Setpoint channels
	logic [NUM_SP-1:0] hit_flag;
	logic [NUM_SP-1:0] out_q;
	logic counting;
	assign counting = (state_reg == CST_COUNTING);

	genvar ch;
	generate
		for (ch = 0; ch < NUM_SP; ch = ch + 1)
		begin : g_sp
			localparam logic [1:0] HI_IDX = 2'(2 * ch);
			localparam logic [1:0] LO_IDX = 2'(2 * ch + 1);
			logic [7:0] hi_reg;
			logic [7:0] hi_next;
			logic [15:0] act_reg;
			logic [15:0] act_next;
			logic [15:0] pend_reg;
			logic [15:0] pend_next;
			logic pend_vld_reg;
			logic pend_vld_next;
			logic hit_reg;
			logic hit_next;
			logic q_reg;
			logic q_next;

			always_comb
			begin
				hi_next = hi_reg;
				act_next = act_reg;
				pend_next = pend_reg;
				pend_vld_next = pend_vld_reg;
				hit_next = hit_reg;
				q_next = q_reg;
				// High byte is held until its low byte completes the word
				if (img_wr && (img_wr_idx == HI_IDX))
					hi_next = img_wr_data;
				if (img_wr && (img_wr_idx == LO_IDX))
				begin
					if (!hit_reg)
						act_next = {hi_reg, img_wr_data};
					else
					begin
						pend_next = {hi_reg, img_wr_data};
						pend_vld_next = 1'b1;
					end
				end
				if (gate_rise)
				begin
					hit_next = 1'b0;
					q_next = 1'b0;
					if (pend_vld_reg)
					begin
						act_next = pend_reg;
						pend_vld_next = 1'b0;
					end
				end
				// Count is zero right after gate rise, so a zero setpoint hits then
				else if (counting && !ovf_reg && !hit_reg && (count_reg == act_reg))
				begin
					hit_next = 1'b1;
					q_next = ~block_reg;
				end
				if (run_fall || ctl_cold_restart)
					q_next = 1'b0;
			end

			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					hi_reg <= BYTE_ZERO;
					act_reg <= SP_RESET;
					pend_reg <= SP_RESET;
					pend_vld_reg <= 1'b0;
					hit_reg <= 1'b0;
					q_reg <= 1'b0;
				end
				else
				begin
					hi_reg <= hi_next;
					act_reg <= act_next;
					pend_reg <= pend_next;
					pend_vld_reg <= pend_vld_next;
					hit_reg <= hit_next;
					q_reg <= q_next;
				end
			end

			assign hit_flag[ch] = hit_reg;
			assign out_q[ch] = q_reg;
		end
	endgenerate

	assign out_q0 = out_q[0];
	assign out_q1 = out_q[1];

	// Status byte
	logic [7:0] status_byte;
	always_comb
	begin
		status_byte = BYTE_ZERO;
		status_byte[ST_SYNC_BIT] = sync_reg;
		status_byte[ST_HIT1_BIT] = hit_flag[0];
		status_byte[ST_HIT2_BIT] = hit_flag[1];
		status_byte[ST_OVF_BIT] = ovf_reg;
		status_byte[ST_MODE_BIT] = mode_sel;
		status_byte[ST_RES_MSB:ST_RES_LSB] = resolution_sel;
	end

	// Input image read
	logic [7:0] rd_data_next;
	logic rd_valid_next;
	logic [7:0] rd_data_reg;
	logic rd_valid_reg;

	always_comb
	begin
		rd_valid_next = img_rd;
		rd_data_next = rd_data_reg;
		if (img_rd)
		begin
			unique case (img_rd_idx)
				IN_IDX_UNUSED: rd_data_next = BYTE_ZERO;
				IN_IDX_STATUS: rd_data_next = status_byte;
				IN_IDX_CNT_HI: rd_data_next = count_reg[15:8];
				IN_IDX_CNT_LO: rd_data_next = count_reg[7:0];
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_reg <= BYTE_ZERO;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign img_rd_data = rd_data_reg;
	assign img_rd_valid = rd_valid_reg;

endmodule : pcn_counter

// ===== test/pcn_counter_chk.sv
/* Port checker for pcn_counter: image reads and output switch-off.
   Bound to every pcn_counter instance; sees top-level ports only. */
`timescale 1ns/1ns
module pcn_counter_chk
	import pcn_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Controller state and switches
	input wire logic ctl_run,
	input wire logic ctl_cold_restart,
	input wire logic mode_sel,
	input wire logic [1:0] resolution_sel,
	// Image read port
	input wire logic img_rd,
	input wire logic [1:0] img_rd_idx,
	input wire logic [7:0] img_rd_data,
	input wire logic img_rd_valid,
	// Field outputs
	input wire logic out_q0,
	input wire logic out_q1
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence rd_of(i);
		img_rd && img_rd_idx == i;
	endsequence
	sequence outs_off;
		!out_q0 && !out_q1;
	endsequence
	rd_valid_a: assert property (img_rd |=> img_rd_valid)
		else $error("read not answered");
	spur_valid_a: assert property (!img_rd |=> !img_rd_valid)
		else $error("valid without read");
	hold_data_a: assert property (!img_rd |=> $stable(img_rd_data))
		else $error("read data moved");
	idx0_zero_a: assert property (rd_of(IN_IDX_UNUSED) |=> img_rd_data == BYTE_ZERO)
		else $error("byte 0 not zero");
	st_mode_a: assert property (rd_of(IN_IDX_STATUS) |=> img_rd_data[4] == $past(mode_sel))
		else $error("mode bit wrong");
	st_res_a: assert property (rd_of(IN_IDX_STATUS) |=>
		img_rd_data[6:5] == $past(resolution_sel)) else $error("resolution bits wrong");
	run_off_a: assert property ($fell(ctl_run) |-> ##[1:2] outs_off)
		else $error("outputs on after stop");
	cold_off_a: assert property (ctl_cold_restart |-> ##[1:2] outs_off)
		else $error("outputs on after restart");
endmodule : pcn_counter_chk

bind pcn_counter pcn_counter_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
	.ctl_run(ctl_run), .ctl_cold_restart(ctl_cold_restart), .mode_sel(mode_sel),
	.resolution_sel(resolution_sel), .img_rd(img_rd), .img_rd_idx(img_rd_idx),
	.img_rd_data(img_rd_data), .img_rd_valid(img_rd_valid), .out_q0(out_q0),
	.out_q1(out_q1));

// ===== test/pcn_host.sv
/* Host controller model: writes setpoints, reads the input image.
   Tasks are called from the bench; signals change after rising edges. */
`timescale 1ns/1ns
module pcn_host
	import pcn_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Output image
	output logic img_wr,
	output logic [1:0] img_wr_idx,
	output logic [7:0] img_wr_data,
	// Input image
	output logic img_rd,
	output logic [1:0] img_rd_idx,
	input wire logic [7:0] img_rd_data
);
	initial
	begin
		img_wr = 1'b0;
		img_wr_idx = 2'h0;
		img_wr_data = 8'h00;
		img_rd = 1'b0;
		img_rd_idx = 2'h0;
	end
	// Value held in 16 bits, high byte first
	task wsp(input logic [1:0] hi, input logic [15:0] v);
		@(posedge ref_clk);
		img_wr <= 1'b1;
		img_wr_idx <= hi;
		img_wr_data <= v[15:8];
		@(posedge ref_clk);
		img_wr_idx <= hi + 2'h1;
		img_wr_data <= v[7:0];
		@(posedge ref_clk);
		img_wr <= 1'b0;
	endtask : wsp
	// Answer comes a fixed cycle after the taking edge
	task rd(input logic [1:0] i, output logic [7:0] d);
		@(posedge ref_clk);
		img_rd <= 1'b1;
		img_rd_idx <= i;
		@(posedge ref_clk);
		img_rd <= 1'b0;
		@(posedge ref_clk);
		d = img_rd_data;
	endtask : rd
endmodule : pcn_host

// ===== test/setpoint_pulse_counter_test.sv
/* Self-checking bench for pcn_counter with the host model.
   Bench drives field pins; host model drives the image port. */
`timescale 1ns/1ns
module setpoint_pulse_counter_test
	import pcn_pkg::*;
;
	logic ref_clk, arst_n, count_pin, gate_pin, mode_sel, ref_sync, ctl_run;
	logic ctl_overall_reset, ctl_cold_restart, img_wr, img_rd, img_rd_valid, out_q0, out_q1;
	logic [1:0] resolution_sel, img_wr_idx, img_rd_idx;
	logic [7:0] img_wr_data, img_rd_data, h, l;
	int err_count, samples_checked, cyc;
	pcn_counter i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .count_pin(count_pin),
		.gate_pin(gate_pin), .out_q0(out_q0), .out_q1(out_q1), .mode_sel(mode_sel),
		.resolution_sel(resolution_sel), .ref_sync(ref_sync), .ctl_run(ctl_run),
		.ctl_overall_reset(ctl_overall_reset), .ctl_cold_restart(ctl_cold_restart),
		.img_wr(img_wr), .img_wr_idx(img_wr_idx), .img_wr_data(img_wr_data),
		.img_rd(img_rd), .img_rd_idx(img_rd_idx), .img_rd_data(img_rd_data),
		.img_rd_valid(img_rd_valid));
	pcn_host i_host (.ref_clk(ref_clk), .img_wr(img_wr), .img_wr_idx(img_wr_idx),
		.img_wr_data(img_wr_data), .img_rd(img_rd), .img_rd_idx(img_rd_idx),
		.img_rd_data(img_rd_data));
	always #4 ref_clk = ~ref_clk;
	task end_sim;
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			end_sim();
		end
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task q(input logic [15:0] e);
		chk({14'h0000, out_q1, out_q0}, e);
	endtask : q
	task cnt(input logic [15:0] e);
		i_host.rd(IN_IDX_CNT_HI, h);
		i_host.rd(IN_IDX_CNT_LO, l);
		chk({h, l}, e);
	endtask : cnt
	// Six cycles cover sync, edge compare and the response
	task gate(input logic v);
		@(posedge ref_clk);
		gate_pin <= v;
		repeat (6) @(posedge ref_clk);
	endtask : gate
	task pulse(input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			count_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			count_pin <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
	endtask : pulse
	task t_zero;
		i_host.rd(IN_IDX_UNUSED, h);
		chk({8'h00, h}, 16'h0000);
		gate(1'b1);
		q(16'h0003);
		cnt(16'h0000);
		i_host.rd(IN_IDX_STATUS, h);
		chk({8'h00, h}, 16'h0026);
		gate(1'b0);
	endtask : t_zero
	task t_count;
		i_host.wsp(OUT_IDX_SP1_HI, 16'h0002);
		i_host.wsp(OUT_IDX_SP2_HI, 16'h0004);
		q(16'h0003);
		gate(1'b1);
		q(16'h0000);
		pulse(1);
		q(16'h0000);
		pulse(1);
		q(16'h0001);
		pulse(2);
		q(16'h0003);
		cnt(16'h0004);
		gate(1'b0);
		pulse(3);
		cnt(16'h0004);
		q(16'h0003);
		@(posedge ref_clk);
		ref_sync <= 1'b1;
		ctl_overall_reset <= 1'b1;
		@(posedge ref_clk);
		ctl_overall_reset <= 1'b0;
		cnt(16'h0000);
		q(16'h0003);
		i_host.rd(IN_IDX_STATUS, h);
		chk({8'h00, h}, 16'h0027);
	endtask : t_count
	task t_stop;
		@(posedge ref_clk);
		ctl_run <= 1'b0;
		repeat (3) @(posedge ref_clk);
		q(16'h0000);
		ctl_run <= 1'b1;
	endtask : t_stop
	task t_imm;
		gate(1'b1);
		i_host.wsp(OUT_IDX_SP1_HI, 16'h0001);
		pulse(1);
		q(16'h0001);
		@(posedge ref_clk);
		ctl_cold_restart <= 1'b1;
		@(posedge ref_clk);
		ctl_cold_restart <= 1'b0;
		pulse(3);
		q(16'h0000);
		cnt(16'h0004);
		gate(1'b0);
	endtask : t_imm
	initial
	begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		count_pin = 1'b0;
		gate_pin = 1'b0;
		mode_sel = 1'b0;
		resolution_sel = 2'h1;
		ref_sync = 1'b0;
		ctl_run = 1'b1;
		ctl_overall_reset = 1'b0;
		ctl_cold_restart = 1'b0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_zero();
		t_count();
		t_stop();
		t_imm();
		end_sim();
	end
endmodule : setpoint_pulse_counter_test
